/* rtl/fsp_consts.svh */
// Constants of the frame security policy block
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH
`define FSP_TEMPORAL_KEY_ID_W      8
`define FSP_EO_W        12
`define FSP_SFC_W       48
`define FSP_EO_ZERO     12'h000
`define FSP_FIFO_DEPTH  32
`define FSP_KEYS        4
`endif

/* rtl/fsp_pkg.sv */
// Types of the frame security policy block
`include "fsp_consts.svh"
package fsp_pkg;
	typedef enum logic [1:0] {FSP_MODE0, FSP_MODE1, FSP_MODE2, FSP_MODE_BAD} fsp_mode_t;
	typedef enum logic [4:0] {FSP_BEACON, FSP_IMM_ACK, FSP_BLK_ACK, FSP_RTS, FSP_CTS, FSP_SPECIAL_A,
		FSP_SPECIAL_B, FSP_APP_CTRL, FSP_RES_REQ, FSP_RES_RSP, FSP_PROBE, FSP_PAIRWISE_CMD,
		FSP_GROUP_CMD, FSP_APP_CMD, FSP_DATA, FSP_AGG_DATA, FSP_OTHER_CMD} fsp_class_t;
	typedef enum logic [1:0] {FSP_PROT_NONE, FSP_PROT_OPT, FSP_PROT_MUST} fsp_prot_t;
	typedef enum logic [2:0] {FSP_EVT_NONE, FSP_EVT_RX_PROT_IN_MODE0, FSP_EVT_RX_NO_REL, FSP_EVT_RX_UNPROT,
		FSP_EVT_RX_UNKNOWN_KEY, FSP_EVT_RX_REPLAY, FSP_EVT_RX_MIC_FAIL, FSP_EVT_TX_NO_REL} fsp_reason_t;
	typedef struct packed {
		logic                   secure;
		logic                   ctr_encrypt;
		logic                   cbc_mac;
		fsp_class_t             fclass;
		logic [`FSP_TEMPORAL_KEY_ID_W-1:0] key_id;
		logic [`FSP_EO_W-1:0]   eo;
		logic [`FSP_SFC_W-1:0]  secure_frame_counter;
	} fsp_dec_t;
endpackage

/* rtl/fsp_top.sv */
// Frame security policy: mode, transmit protection decisions, receive filtering
`timescale 1ns/10ps
`include "fsp_consts.svh"

// Decision FIFO between policy and cipher engine
module fsp_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 32
) (
	input  wire logic         clk_in,
	input  wire logic         reset_in,
	input  wire logic         ce_in,
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	input  wire logic [W-1:0] in_data_in,
	output logic              out_valid_out,
	input  wire logic         out_ready_in,
	output logic [W-1:0]      out_data_out
);
	localparam int AW = $clog2(DEPTH);

	initial
	begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("fsp_fifo: DEPTH must be a power of two of at least 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW:0]             wr;
		logic [AW:0]             rd;
	} fifo_st_t;

	fifo_st_t f_reg;
	fifo_st_t f_next;
	logic     full;
	logic     empty;

	// Pointer compare with wrap bit
	assign full          = (f_reg.wr[AW] != f_reg.rd[AW]) && (f_reg.wr[AW-1:0] == f_reg.rd[AW-1:0]);
	assign empty         = (f_reg.wr == f_reg.rd);
	assign in_ready_out  = !full;
	assign out_valid_out = !empty;
	assign out_data_out  = f_reg.mem[f_reg.rd[AW-1:0]];

	// Write and read pointer update
	always_comb
	begin
		f_next = f_reg;
		if (in_valid_in && !full)
		begin
			f_next.mem[f_reg.wr[AW-1:0]] = in_data_in;
			f_next.wr = f_reg.wr + 1'b1;
		end
		if (out_ready_in && !empty)
			f_next.rd = f_reg.rd + 1'b1;
	end

	// State register
	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
			f_reg <= '0;
		else if (ce_in)
			f_reg <= f_next;
	end
endmodule

// Policy core
module fsp_top #(
	parameter int KEYS       = `FSP_KEYS,
	parameter int FIFO_DEPTH = `FSP_FIFO_DEPTH
) (
	input  wire logic                   clk_in,
	input  wire logic                   reset_in,
	input  wire logic                   ce_in,
	input  fsp_pkg::fsp_mode_t          mode_sel_in,
	input  wire logic                   mode_load_in,
	output fsp_pkg::fsp_mode_t          mode_out,
	input  wire logic                   tx_valid_in,
	output logic                        tx_ready_out,
	input  fsp_pkg::fsp_class_t         tx_class_in,
	input  wire logic                   tx_want_secure_in,
	input  wire logic                   tx_group_in,
	input  wire logic                   tx_peer_secure_in,
	input  wire logic [`FSP_TEMPORAL_KEY_ID_W-1:0] tx_sdu_key_id_in,
	input  wire logic [`FSP_TEMPORAL_KEY_ID_W-1:0] tx_pairwise_key_id_in,
	input  wire logic [`FSP_TEMPORAL_KEY_ID_W-1:0] tx_group_key_id_in,
	input  wire logic [`FSP_EO_W-1:0]   tx_payload_len_in,
	input  wire logic [`FSP_EO_W-1:0]   tx_agg_hdr_len_in,
	input  wire logic [`FSP_EO_W-1:0]   tx_app_eo_in,
	input  wire logic [`FSP_EO_W-1:0]   tx_var_eo_in,
	output logic                        dec_valid_out,
	input  wire logic                   dec_ready_in,
	output fsp_pkg::fsp_dec_t           dec_out,
	input  wire logic                   rx_valid_in,
	input  fsp_pkg::fsp_class_t         rx_class_in,
	input  wire logic                   rx_secure_in,
	input  wire logic                   rx_peer_secure_in,
	input  wire logic [`FSP_TEMPORAL_KEY_ID_W-1:0] rx_key_id_in,
	input  wire logic                   rx_key_known_in,
	input  wire logic [`FSP_SFC_W-1:0]  rx_sfc_in,
	output logic                        rx_accept_out,
	output logic                        rx_drop_out,
	input  wire logic                   mic_fail_in,
	input  fsp_pkg::fsp_class_t         mic_class_in,
	output logic                        evt_valid_out,
	output fsp_pkg::fsp_reason_t        evt_reason_out,
	output fsp_pkg::fsp_class_t         evt_class_out
);
	import fsp_pkg::*;

	localparam int SW = $clog2(KEYS);

	initial
	begin
		if (KEYS < 2 || (1 << SW) != KEYS || SW > `FSP_TEMPORAL_KEY_ID_W)
			$error("fsp_top: KEYS must be a power of two from 2 to 2**TEMPORAL_KEY_ID_W");
	end

	typedef struct packed {
		fsp_mode_t                          mode;
		logic [KEYS-1:0][`FSP_SFC_W-1:0]    secure_frame_counter;
		logic [KEYS-1:0][`FSP_SFC_W-1:0]    replay;
		logic                               rx_accept;
		logic                               rx_drop;
		logic                               evt_valid;
		fsp_reason_t                        evt_reason;
		fsp_class_t                         evt_class;
		logic                               mic_pend;
		fsp_class_t                         mic_class;
	} st_t;

	st_t       s_reg;
	st_t       s_next;
	fsp_dec_t  push_dec;
	logic      push;
	logic      fifo_ready;
	logic      tx_fire;
	logic      tx_block;
	logic      tx_secure;
	logic [SW-1:0] tx_slot;
	logic [SW-1:0] rx_slot;
	fsp_prot_t tx_prot;
	fsp_prot_t rx_prot;

	// Protection class of each frame type
	function automatic fsp_prot_t prot_of(input fsp_class_t c);
		case (c)
			FSP_BEACON, FSP_IMM_ACK, FSP_BLK_ACK, FSP_RTS, FSP_CTS,
			FSP_SPECIAL_A, FSP_SPECIAL_B: prot_of = FSP_PROT_NONE;
			FSP_APP_CTRL, FSP_RES_REQ, FSP_RES_RSP, FSP_PROBE,
			FSP_PAIRWISE_CMD, FSP_APP_CMD: prot_of = FSP_PROT_OPT;
			FSP_GROUP_CMD: prot_of = FSP_PROT_MUST;
			FSP_DATA, FSP_AGG_DATA: prot_of = FSP_PROT_MUST;
			default: prot_of = FSP_PROT_NONE;
		endcase
	endfunction

	// Counter slot of a key id
	function automatic logic [SW-1:0] key_slot(input logic [`FSP_TEMPORAL_KEY_ID_W-1:0] id);
		key_slot = id[SW-1:0];
	endfunction

	// ---------------------------------------------------------------
	// Transmit decision
	// ---------------------------------------------------------------
	assign tx_prot   = prot_of(tx_class_in);
	assign tx_secure = (s_reg.mode != FSP_MODE0) && tx_peer_secure_in
		&& (tx_prot == FSP_PROT_MUST || (tx_prot == FSP_PROT_OPT && (tx_want_secure_in
		|| s_reg.mode == FSP_MODE2)));
	assign tx_block     = (s_reg.mode == FSP_MODE2) && !tx_peer_secure_in && tx_prot == FSP_PROT_MUST;
	assign tx_ready_out = fifo_ready && !rx_valid_in;
	assign tx_fire      = ce_in && tx_valid_in && tx_ready_out;
	assign push         = tx_fire && !tx_block;
	assign tx_slot      = key_slot(push_dec.key_id);

	// Key, offset and counter of the outgoing frame
	always_comb
	begin
		push_dec             = '0;
		push_dec.secure      = tx_secure;
		push_dec.ctr_encrypt = tx_secure;
		push_dec.cbc_mac     = tx_secure;
		push_dec.fclass      = tx_class_in;
		if (tx_class_in == FSP_DATA || tx_class_in == FSP_AGG_DATA)
			push_dec.key_id = tx_sdu_key_id_in;
		else if (tx_group_in)
			push_dec.key_id = tx_group_key_id_in;
		else
			push_dec.key_id = tx_pairwise_key_id_in;
		case (tx_class_in)
			FSP_PAIRWISE_CMD, FSP_GROUP_CMD: push_dec.eo = `FSP_EO_ZERO;
			FSP_RES_REQ, FSP_RES_RSP: push_dec.eo = tx_payload_len_in;
			FSP_AGG_DATA: push_dec.eo = tx_agg_hdr_len_in;
			FSP_DATA, FSP_PROBE: push_dec.eo = tx_var_eo_in;
			FSP_APP_CTRL, FSP_APP_CMD: push_dec.eo = tx_app_eo_in;
			default: push_dec.eo = `FSP_EO_ZERO;
		endcase
		if (!tx_secure)
			push_dec.eo = `FSP_EO_ZERO;
		push_dec.secure_frame_counter = s_reg.secure_frame_counter[key_slot(push_dec.key_id)];
	end

	fsp_fifo #(
		.W     ($bits(fsp_dec_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in        (clk_in),
		.reset_in      (reset_in),
		.ce_in         (ce_in),
		.in_valid_in   (push),
		.in_ready_out  (fifo_ready),
		.in_data_in    (push_dec),
		.out_valid_out (dec_valid_out),
		.out_ready_in  (dec_ready_in),
		.out_data_out  (dec_out)
	);

	// ---------------------------------------------------------------
	// Mode, receive filter and events
	// ---------------------------------------------------------------
	assign rx_prot = prot_of(rx_class_in);
	assign rx_slot = key_slot(rx_key_id_in);

	always_comb
	begin
		s_next            = s_reg;
		s_next.rx_accept  = 1'b0;
		s_next.rx_drop    = 1'b0;
		s_next.evt_valid  = 1'b0;
		s_next.evt_reason = FSP_EVT_NONE;
		// Mode 1 reached only by explicit load
		if (mode_load_in && mode_sel_in != FSP_MODE_BAD)
			s_next.mode = mode_sel_in;
		// Per-key frame counter advance
		if (push && tx_secure)
			s_next.secure_frame_counter[tx_slot] = s_reg.secure_frame_counter[tx_slot] + 1'b1;
		// Pending integrity failure, set wins over clear
		if (mic_fail_in)
			s_next.mic_class = mic_class_in;
		if (rx_valid_in)
		begin
			s_next.rx_drop   = 1'b1;
			s_next.evt_valid = 1'b1;
			s_next.evt_class = rx_class_in;
			if (rx_secure_in && s_reg.mode == FSP_MODE0)
				s_next.evt_reason = FSP_EVT_RX_PROT_IN_MODE0;
			else if (rx_secure_in && !rx_peer_secure_in)
				s_next.evt_reason = FSP_EVT_RX_NO_REL;
			else if (!rx_secure_in && rx_peer_secure_in && rx_prot == FSP_PROT_MUST && s_reg.mode != FSP_MODE0)
				s_next.evt_reason = FSP_EVT_RX_UNPROT;
			else if (rx_secure_in && !rx_key_known_in)
				s_next.evt_reason = FSP_EVT_RX_UNKNOWN_KEY;
			else if (rx_secure_in && rx_sfc_in <= s_reg.replay[rx_slot])
				s_next.evt_reason = FSP_EVT_RX_REPLAY;
			else
			begin
				s_next.rx_drop   = 1'b0;
				s_next.evt_valid = 1'b0;
				s_next.rx_accept = 1'b1;
				if (rx_secure_in)
					s_next.replay[rx_slot] = rx_sfc_in;
			end
			s_next.mic_pend = s_reg.mic_pend || mic_fail_in;
		end
		else if (tx_fire && tx_block)
		begin
			s_next.evt_valid  = 1'b1;
			s_next.evt_reason = FSP_EVT_TX_NO_REL;
			s_next.evt_class  = tx_class_in;
			s_next.mic_pend   = s_reg.mic_pend || mic_fail_in;
		end
		else if (s_reg.mic_pend || mic_fail_in)
		begin
			s_next.evt_valid  = 1'b1;
			s_next.evt_reason = FSP_EVT_RX_MIC_FAIL;
			s_next.evt_class  = s_reg.mic_pend ? s_reg.mic_class : mic_class_in;
			s_next.mic_pend   = s_reg.mic_pend && mic_fail_in;
		end
	end

	// State register, frozen while clock enable low
	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
			s_reg <= '0;
		else if (ce_in)
			s_reg <= s_next;
	end

	assign mode_out       = s_reg.mode;
	assign rx_accept_out  = s_reg.rx_accept;
	assign rx_drop_out    = s_reg.rx_drop;
	assign evt_valid_out  = s_reg.evt_valid;
	assign evt_reason_out = s_reg.evt_reason;
	assign evt_class_out  = s_reg.evt_class;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	property p_mode1_explicit;
		(mode_out == FSP_MODE1 && $past(mode_out) != FSP_MODE1)
			|-> $past(ce_in && mode_load_in && mode_sel_in == FSP_MODE1);
	endproperty
	a_mode1_explicit: assert property (p_mode1_explicit) else $error("mode 1 entered without load");

	property p_mode0_clear;
		push && s_reg.mode == FSP_MODE0 |-> !push_dec.secure;
	endproperty
	a_mode0_clear: assert property (p_mode0_clear) else $error("protected frame sent in mode 0");

	property p_ctrl_clear;
		push && prot_of(tx_class_in) == FSP_PROT_NONE |-> !push_dec.secure;
	endproperty
	a_ctrl_clear: assert property (p_ctrl_clear) else $error("unprotected-only frame protected");

	property p_data_secure;
		push && s_reg.mode != FSP_MODE0 && tx_peer_secure_in
			&& (tx_class_in == FSP_DATA || tx_class_in == FSP_AGG_DATA)
			|-> push_dec.secure && push_dec.key_id == tx_sdu_key_id_in;
	endproperty
	a_data_secure: assert property (p_data_secure) else $error("data frame not protected");

	property p_keycmd_eo;
		push && push_dec.secure && (tx_class_in == FSP_PAIRWISE_CMD || tx_class_in == FSP_GROUP_CMD)
			|-> push_dec.eo == `FSP_EO_ZERO;
	endproperty
	a_keycmd_eo: assert property (p_keycmd_eo) else $error("key command offset not zero");

	property p_rx_mode0;
		ce_in && rx_valid_in && rx_secure_in && mode_out == FSP_MODE0
			|=> rx_drop_out && evt_valid_out && evt_reason_out == FSP_EVT_RX_PROT_IN_MODE0;
	endproperty
	a_rx_mode0: assert property (p_rx_mode0) else $error("protected frame kept in mode 0");

	property p_rx_norel;
		ce_in && rx_valid_in && rx_secure_in && !rx_peer_secure_in && mode_out != FSP_MODE0
			|=> rx_drop_out && !rx_accept_out && evt_reason_out == FSP_EVT_RX_NO_REL;
	endproperty
	a_rx_norel: assert property (p_rx_norel) else $error("frame without relationship kept");

	property p_rx_unprot;
		ce_in && rx_valid_in && !rx_secure_in && rx_peer_secure_in && mode_out != FSP_MODE0
			&& prot_of(rx_class_in) == FSP_PROT_MUST |=> rx_drop_out && evt_reason_out == FSP_EVT_RX_UNPROT;
	endproperty
	a_rx_unprot: assert property (p_rx_unprot) else $error("unprotected must-secure frame kept");

	property p_mic_report;
		ce_in && mic_fail_in && !rx_valid_in && !(tx_fire && tx_block)
			|=> evt_valid_out && evt_reason_out == FSP_EVT_RX_MIC_FAIL;
	endproperty
	a_mic_report: assert property (p_mic_report) else $error("integrity failure not reported");

	property p_sfc_step;
		push && tx_secure |=> !ce_in || s_reg.secure_frame_counter[$past(tx_slot)] == $past(push_dec.secure_frame_counter) + 1'b1;
	endproperty
	a_sfc_step: assert property (p_sfc_step) else $error("frame counter did not advance");

	c_mode1: cover property (mode_load_in && ce_in && mode_sel_in == FSP_MODE1 ##1 mode_out == FSP_MODE1);
	c_tx_secure: cover property (push && push_dec.secure);
	c_rx_drop: cover property (rx_drop_out);
	c_fifo_full: cover property (tx_valid_in && !fifo_ready);
endmodule

/* dv/fsp_cipher_model.sv */
// Cipher engine model that pops policy decisions from the decision FIFO
`timescale 1ns/10ps
module fsp_cipher_model (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        stall_in,
	input  wire logic        dec_valid_in,
	input  fsp_pkg::fsp_dec_t dec_in,
	output logic             dec_ready_out
);
	import fsp_pkg::*;
	fsp_dec_t got[$];
	// Take one word per cycle unless told to stall
	always @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
			dec_ready_out <= 1'b0;
		else
		begin
			if (dec_valid_in && dec_ready_out)
				got.push_back(dec_in);
			dec_ready_out <= !stall_in;
		end
	end
endmodule

/* dv/frame_security_policy_tb.sv */
// Self-checking bench of the frame security policy block
`timescale 1ns/10ps
module frame_security_policy_tb;
	import fsp_pkg::*;
	logic        clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic        mode_load = 1'b0, tx_valid = 1'b0, tx_want = 1'b0, tx_group = 1'b0, tx_peer = 1'b0, stall = 1'b0;
	logic        rx_valid = 1'b0, rx_secure = 1'b0, rx_peer = 1'b0, rx_known = 1'b0, mic_fail = 1'b0;
	logic        ce = 1'b1;
	fsp_mode_t   mode_sel = FSP_MODE0;
	fsp_class_t  tx_class = FSP_BEACON, rx_class = FSP_BEACON, mic_class = FSP_BEACON;
	logic [7:0]  kbase = 8'h10;
	logic [11:0] ebase = 12'h100;
	logic [47:0] rx_sfc = 48'h000000000001;
	logic        tx_ready, dec_valid, dec_ready, rx_accept, rx_drop, evt_valid;
	fsp_mode_t   mode_now;
	fsp_dec_t    dec;
	fsp_reason_t evt_reason;
	fsp_class_t  evt_class;
	int          mismatches = 0;
	int          n_checks = 0;

	// Clock of 100 ns period
	always #50 clk_in = ~clk_in;

	fsp_top uut (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce), .mode_sel_in(mode_sel),
		.mode_load_in(mode_load), .mode_out(mode_now), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
		.tx_class_in(tx_class), .tx_want_secure_in(tx_want), .tx_group_in(tx_group), .tx_peer_secure_in(tx_peer),
		.tx_sdu_key_id_in(kbase + 8'h01), .tx_pairwise_key_id_in(kbase + 8'h02), .tx_group_key_id_in(kbase + 8'h03),
		.tx_payload_len_in(ebase + 12'h001), .tx_agg_hdr_len_in(ebase + 12'h002), .tx_app_eo_in(ebase + 12'h003),
		.tx_var_eo_in(ebase + 12'h004), .dec_valid_out(dec_valid), .dec_ready_in(dec_ready), .dec_out(dec),
		.rx_valid_in(rx_valid), .rx_class_in(rx_class), .rx_secure_in(rx_secure), .rx_peer_secure_in(rx_peer),
		.rx_key_id_in(kbase + 8'h01), .rx_key_known_in(rx_known), .rx_sfc_in(rx_sfc), .rx_accept_out(rx_accept),
		.rx_drop_out(rx_drop), .mic_fail_in(mic_fail), .mic_class_in(mic_class), .evt_valid_out(evt_valid),
		.evt_reason_out(evt_reason), .evt_class_out(evt_class));

	fsp_cipher_model pm (.clk_in(clk_in), .reset_in(reset_in), .stall_in(stall), .dec_valid_in(dec_valid),
		.dec_in(dec), .dec_ready_out(dec_ready));

	// Expected decision of one frame sent to a related peer
	function automatic fsp_dec_t expect_dec(input fsp_mode_t m, input fsp_class_t c, input logic want, grp);
		fsp_dec_t d;
		logic     must;
		logic     opt;
		d = '0;
		must = c inside {FSP_GROUP_CMD, FSP_DATA, FSP_AGG_DATA};
		opt = c inside {FSP_APP_CTRL, FSP_RES_REQ, FSP_RES_RSP, FSP_PROBE, FSP_PAIRWISE_CMD, FSP_APP_CMD};
		d.secure = (m != FSP_MODE0) && (must || (opt && (want || m == FSP_MODE2)));
		d.ctr_encrypt = d.secure;
		d.cbc_mac = d.secure;
		d.fclass = c;
		d.key_id = (c inside {FSP_DATA, FSP_AGG_DATA}) ? kbase + 8'h01 : (grp ? kbase + 8'h03 : kbase + 8'h02);
		if (d.secure)
			case (c)
				FSP_RES_REQ, FSP_RES_RSP: d.eo = ebase + 12'h001;
				FSP_AGG_DATA: d.eo = ebase + 12'h002;
				FSP_APP_CTRL, FSP_APP_CMD: d.eo = ebase + 12'h003;
				FSP_DATA, FSP_PROBE: d.eo = ebase + 12'h004;
				default: d.eo = 12'h000;
			endcase
		else
			d.key_id = '0;
		return d;
	endfunction

	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask

	task automatic set_mode(input fsp_mode_t m, input fsp_mode_t e);
		@(posedge clk_in);
		mode_load <= 1'b1;
		mode_sel <= m;
		@(posedge clk_in);
		mode_load <= 1'b0;
		#1 chk(mode_now === e, "mode output wrong");
	endtask

	// Hold the request until the edge that sees ready
	task automatic send(input fsp_class_t c, input logic want, grp, peer);
		int k;
		@(posedge clk_in);
		tx_valid <= 1'b1;
		tx_class <= c;
		tx_want <= want;
		tx_group <= grp;
		tx_peer <= peer;
		k = 0;
		@(negedge clk_in);
		while (tx_ready !== 1'b1 && k < 100)
		begin
			@(negedge clk_in);
			k++;
		end
		@(posedge clk_in);
		tx_valid <= 1'b0;
	endtask

	task automatic wait_words(input int n);
		int k;
		k = 0;
		while (pm.got.size() < n && k < 200)
		begin
			@(posedge clk_in);
			#1 k++;
		end
		chk(pm.got.size() == n, "decision words missing");
	endtask

	task automatic wait_evt(input fsp_reason_t r, input fsp_class_t c);
		int k;
		k = 0;
		#1;
		while (evt_valid !== 1'b1 && k < 5)
		begin
			@(posedge clk_in);
			#1 k++;
		end
		chk(evt_valid === 1'b1 && evt_reason === r && evt_class === c, "event wrong");
		@(posedge clk_in);
		#1 chk(evt_valid === 1'b0, "event longer than one cycle");
	endtask

	// A mode load while the clock enable is low must be ignored
	task automatic ce_freeze;
		@(posedge clk_in);
		ce <= 1'b0;
		mode_load <= 1'b1;
		mode_sel <= FSP_MODE0;
		@(posedge clk_in);
		ce <= 1'b1;
		mode_load <= 1'b0;
		#1 chk(mode_now === FSP_MODE1, "mode changed while frozen");
		@(posedge clk_in);
		#1 chk(mode_now === FSP_MODE1, "mode changed after freeze");
	endtask

	// Replayed counter value is dropped, a fresh one accepted
	task automatic rx_replay;
		rx(1'b1, 1'b1, FSP_DATA, 1'b1, 1'b0, FSP_EVT_NONE);
		@(posedge clk_in);
		rx_sfc <= rx_sfc - 48'h000000000001;
		rx(1'b1, 1'b1, FSP_DATA, 1'b1, 1'b1, FSP_EVT_RX_REPLAY);
		rx(1'b1, 1'b1, FSP_DATA, 1'b1, 1'b0, FSP_EVT_NONE);
	endtask

	// Every class, both wishes, in one mode
	task automatic tx_table(input fsp_mode_t m);
		fsp_dec_t g;
		fsp_dec_t e;
		set_mode(m, m);
		@(posedge clk_in);
		kbase <= {m, 6'h04};
		ebase <= {m, 10'h155};
		for (int i = 0; i <= 16; i++)
			for (int w = 0; w < 2; w++)
			begin
				send(fsp_class_t'(i), w[0], i[0], 1'b1);
				wait_words(1);
				g = pm.got.pop_front();
				e = expect_dec(m, fsp_class_t'(i), w[0], i[0]);
				g.secure_frame_counter = '0;
				if (!g.secure)
					g.key_id = '0;
				chk(g === e, "transmit decision wrong");
			end
	endtask

	task automatic rx(input logic sec, peer, input fsp_class_t c, input logic known, drop, input fsp_reason_t r);
		@(posedge clk_in);
		rx_valid <= 1'b1;
		rx_secure <= sec;
		rx_peer <= peer;
		rx_class <= c;
		rx_known <= known;
		rx_sfc <= rx_sfc + 48'h000000000001;
		@(posedge clk_in);
		rx_valid <= 1'b0;
		#1 chk(rx_drop === drop && rx_accept === !drop, "receive verdict wrong");
		if (drop)
			chk(evt_valid === 1'b1 && evt_reason === r && evt_class === c, "receive event wrong");
	endtask

	// Fill the FIFO with the partner stalled, then drain in order
	task automatic fifo_fill;
		stall <= 1'b1;
		repeat (2) @(posedge clk_in);
		for (int i = 0; i < 32; i++)
			send(FSP_DATA, 1'b0, 1'b0, 1'b1);
		@(negedge clk_in);
		chk(tx_ready === 1'b0, "full FIFO still ready");
		stall <= 1'b0;
		wait_words(32);
		for (int i = 1; i < 32; i++)
			chk(pm.got[i].secure_frame_counter === pm.got[0].secure_frame_counter + 48'(i), "counter order wrong");
		pm.got.delete();
		chk(dec_valid === 1'b0, "FIFO not empty");
	endtask

	task automatic test_done;
		$display("Checks %0d, mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Watchdog
	initial
	begin
		#2000000;
		mismatches++;
		$display("Error at %0t: watchdog expired", $time);
		test_done;
	end

	// Main sequence
	initial
	begin
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		#1 chk(mode_now === FSP_MODE0 && dec_valid === 1'b0 && evt_valid === 1'b0, "reset state wrong");
		set_mode(FSP_MODE_BAD, FSP_MODE0);
		tx_table(FSP_MODE0);
		rx(1'b1, 1'b0, FSP_DATA, 1'b1, 1'b1, FSP_EVT_RX_PROT_IN_MODE0);
		rx(1'b0, 1'b0, FSP_DATA, 1'b1, 1'b0, FSP_EVT_NONE);
		tx_table(FSP_MODE2);
		send(FSP_DATA, 1'b0, 1'b0, 1'b0);
		wait_evt(FSP_EVT_TX_NO_REL, FSP_DATA);
		chk(pm.got.size() == 0, "unrelated data frame queued");
		rx(1'b1, 1'b0, FSP_PROBE, 1'b1, 1'b1, FSP_EVT_RX_NO_REL);
		rx(1'b0, 1'b1, FSP_DATA, 1'b1, 1'b1, FSP_EVT_RX_UNPROT);
		rx(1'b1, 1'b1, FSP_GROUP_CMD, 1'b0, 1'b1, FSP_EVT_RX_UNKNOWN_KEY);
		rx(1'b1, 1'b1, FSP_DATA, 1'b1, 1'b0, FSP_EVT_NONE);
		tx_table(FSP_MODE1);
		rx(1'b0, 1'b1, FSP_RES_REQ, 1'b1, 1'b0, FSP_EVT_NONE);
		rx(1'b0, 1'b1, FSP_AGG_DATA, 1'b1, 1'b1, FSP_EVT_RX_UNPROT);
		rx_replay;
		ce_freeze;
		@(posedge clk_in);
		mic_fail <= 1'b1;
		mic_class <= FSP_AGG_DATA;
		@(posedge clk_in);
		mic_fail <= 1'b0;
		wait_evt(FSP_EVT_RX_MIC_FAIL, FSP_AGG_DATA);
		fifo_fill;
		test_done;
	end
endmodule
